/* File: core/scr_pin_mux.sv */
`default_nettype none
module scr_pin_mux (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [5:0] select_next_in,
  input wire logic [5:0] ext_mem_address_line_in,
  input wire logic ext_mem_drive_in,
  input wire logic [5:0] general_io_line_out_in,
  input wire logic [5:0] general_io_line_oe_in,
  input wire logic [5:0] pad_sync_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe_out,
  output logic [5:0] general_io_line_in_out
);
  import scr_pkg::*;

  // One routing slice per shared pin; built from the next select value
  // so the pin follows the register on the same edge it is written
  for (genvar i = 0; i < SCR_PIN_COUNT; i++)
  begin : g_pin
    logic out_d;
    logic oe_d;
    logic in_d;
    assign out_d = select_next_in[i] ? general_io_line_out_in[i] : ext_mem_address_line_in[i];
    assign oe_d = select_next_in[i] ? general_io_line_oe_in[i] : ext_mem_drive_in;
    assign in_d = select_next_in[i] & pad_sync_in[i];

    // Registered pad drive, released in reset
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        pad_out[i] <= 1'b0;
        pad_oe_out[i] <= 1'b0;
        general_io_line_in_out[i] <= 1'b0;
      end
      else
      begin
        pad_out[i] <= out_d;
        pad_oe_out[i] <= oe_d;
        general_io_line_in_out[i] <= in_d;
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/scr_pkg.sv */
`default_nettype none
package scr_pkg;

  // Register word index; byte address is four times the index
  typedef logic [14:0] scr_index_t;

  localparam scr_index_t SCR_IDX_CLOCK_GATE_1 = 15'h1c02;
  localparam scr_index_t SCR_IDX_CLOCK_GATE_2 = 15'h1c03;
  localparam scr_index_t SCR_IDX_USB_SYSTEM = 15'h1c32;
  localparam scr_index_t SCR_IDX_MEM_SYSTEM = 15'h1c33;
  localparam scr_index_t SCR_IDX_REGULATOR = 15'h7004;
  localparam scr_index_t SCR_IDX_PIN_SELECT = 15'h1c40;
  localparam scr_index_t SCR_IDX_IDLE_CONFIG = 15'h1c41;
  localparam scr_index_t SCR_IDX_BOOT_STATUS = 15'h1c42;

  // Values after reset
  localparam logic [15:0] SCR_RST_CLOCK_GATE = 16'h0000;
  localparam logic [15:0] SCR_RST_SYSTEM = 16'h0000;
  localparam logic [15:0] SCR_RST_REGULATOR = 16'h0000;
  localparam logic [15:0] SCR_RST_PIN_SELECT = 16'h0000;
  localparam logic [15:0] SCR_RST_IDLE = 16'h0000;

  // Writable bits; all others read as zero
  localparam logic [15:0] SCR_MASK_FULL = 16'hffff;
  localparam logic [15:0] SCR_MASK_SYSTEM = 16'h0003;
  localparam logic [15:0] SCR_MASK_REGULATOR = 16'h0003;
  localparam logic [15:0] SCR_MASK_PIN_SELECT = 16'h003f;

  // Field positions
  localparam int unsigned SCR_BIT_USB_REG_EN = 0;
  localparam int unsigned SCR_BIT_CORE_VSEL = 1;
  localparam int unsigned SCR_BIT_IDLE_CPU = 0;
  localparam int unsigned SCR_BIT_STAT_BOOT = 0;
  localparam int unsigned SCR_LSB_STAT_PAD = 8;
  localparam int unsigned SCR_PIN_COUNT = 6;

  // Byte access codes
  localparam logic [1:0] SCR_ACCESS_WORD = 2'h0;
  localparam logic [1:0] SCR_ACCESS_HIGH = 2'h1;
  localparam logic [1:0] SCR_ACCESS_LOW = 2'h2;

  // Boot sequencing state
  typedef enum logic [0:0] {SCR_BOOT_ACTIVE, SCR_BOOT_DONE} scr_boot_state_t;

  // Classic Wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scr_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } scr_wb_rsp_t;

endpackage
`default_nettype wire

/* File: core/scr_top.sv */
// Contract
// - Bit 5 routes address 20 or GPIO 26
// - Bit 4 routes address 19 or GPIO 25
// - Bit 3 routes address 18 or GPIO 24
// - Bit 2 routes address 17 or GPIO 23
// - Bit 1 routes address 16 or GPIO 22
// - Bit 0 routes address 15 or GPIO 21
// - Bit 1 selects core voltage, 1.3 V default
// - USB regulator enable bit 0, off at reset
// - Reset leaves 16-bit accesses on both spaces
// - Memory byte field: 01 high, 10 low
// - USB control holds its own byte field
// - Boot end: clocks off, non-CPU domains idle
// - Two gate registers enable each peripheral clock
// - Probed peripheral clocked, disabled if boot fails
//
// The Wishbone slave port was decided locally.
`default_nettype none
module scr_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire scr_pkg::scr_wb_req_t wb_req_in,
  output scr_pkg::scr_wb_rsp_t wb_rsp_out,
  input wire logic boot_probe_start_in,
  input wire logic boot_probe_fail_in,
  input wire logic [4:0] boot_probe_index_in,
  input wire logic boot_done_in,
  input wire logic [5:0] ext_mem_address_line_in,
  input wire logic ext_mem_drive_in,
  input wire logic [5:0] general_io_line_out_in,
  input wire logic [5:0] general_io_line_oe_in,
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe_out,
  output logic [5:0] general_io_line_in_out,
  output logic [31:0] periph_clock_enable_out,
  output logic [15:0] idle_request_out,
  output logic core_voltage_select_out,
  output logic usb_regulator_enable_out,
  output logic [1:0] mem_byte_access_out,
  output logic [1:0] usb_byte_access_out,
  output logic boot_active_out
);
  import scr_pkg::*;

  // Byte-lane merge of a write into a register, reserved bits kept zero
  function automatic logic [15:0] scr_merge(
    input logic [15:0] old_value,
    input logic [15:0] new_value,
    input logic [1:0] lanes,
    input logic [15:0] mask
  );
    logic [15:0] lane_bits;
    lane_bits = {{8{lanes[1]}}, {8{lanes[0]}}};
    return ((new_value & lane_bits) | (old_value & ~lane_bits)) & mask;
  endfunction

  // One-hot of a 5-bit peripheral number
  function automatic logic [31:0] scr_onehot(input logic [4:0] index);
    logic [31:0] hot;
    hot = 32'h0000_0000;
    hot[index] = 1'b1;
    return hot;
  endfunction

  // Bus side
  logic write_strobe;
  logic addr_ok;
  scr_index_t index;
  logic [15:0] write_data;
  logic [1:0] byte_enable;
  logic [15:0] read_data;

  // Registers and next values
  logic [15:0] gate1_q;
  logic [15:0] gate1_d;
  logic [15:0] gate2_q;
  logic [15:0] gate2_d;
  logic [15:0] usb_sys_q;
  logic [15:0] usb_sys_d;
  logic [15:0] mem_sys_q;
  logic [15:0] mem_sys_d;
  logic [15:0] regulator_q;
  logic [15:0] regulator_d;
  logic [15:0] pin_select_q;
  logic [15:0] pin_select_d;
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  scr_boot_state_t boot_state_q;
  scr_boot_state_t boot_state_d;

  // Pad input synchronisers
  logic [5:0] pad_meta_q;
  logic [5:0] pad_sync_q;

  // Named pin selects
  logic addr20_pin_select;
  logic addr19_pin_select;
  logic addr18_pin_select;
  logic addr17_pin_select;
  logic addr16_pin_select;
  logic addr15_pin_select;

  // Address decode
  logic hit_gate1;
  logic hit_gate2;
  logic hit_usb_sys;
  logic hit_mem_sys;
  logic hit_regulator;
  logic hit_pin_select;
  logic hit_idle;
  logic hit_status;

  // Boot events
  logic boot_finish;
  logic [31:0] probe_hot;
  logic [31:0] probe_set;
  logic [31:0] probe_clear;
  logic [31:0] gates_written;
  logic [31:0] gates_next;
  logic [15:0] status_value;
  logic boot_active_q;

  scr_wb_slave u_slave (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wb_req_in(wb_req_in),
    .read_data_in(read_data),
    .wb_rsp_out(wb_rsp_out),
    .write_strobe_out(write_strobe),
    .addr_ok_out(addr_ok),
    .index_out(index),
    .write_data_out(write_data),
    .byte_enable_out(byte_enable)
  );

  // Decode of the word index; misses read zero and ignore writes
  assign hit_gate1 = addr_ok & (index == SCR_IDX_CLOCK_GATE_1);
  assign hit_gate2 = addr_ok & (index == SCR_IDX_CLOCK_GATE_2);
  assign hit_usb_sys = addr_ok & (index == SCR_IDX_USB_SYSTEM);
  assign hit_mem_sys = addr_ok & (index == SCR_IDX_MEM_SYSTEM);
  assign hit_regulator = addr_ok & (index == SCR_IDX_REGULATOR);
  assign hit_pin_select = addr_ok & (index == SCR_IDX_PIN_SELECT);
  assign hit_idle = addr_ok & (index == SCR_IDX_IDLE_CONFIG);
  assign hit_status = addr_ok & (index == SCR_IDX_BOOT_STATUS);

  // Plain software-written registers
  assign usb_sys_d = (write_strobe & hit_usb_sys) ?
    scr_merge(usb_sys_q, write_data, byte_enable, SCR_MASK_SYSTEM) : usb_sys_q;
  assign mem_sys_d = (write_strobe & hit_mem_sys) ?
    scr_merge(mem_sys_q, write_data, byte_enable, SCR_MASK_SYSTEM) : mem_sys_q;
  assign regulator_d = (write_strobe & hit_regulator) ?
    scr_merge(regulator_q, write_data, byte_enable, SCR_MASK_REGULATOR) : regulator_q;
  assign pin_select_d = (write_strobe & hit_pin_select) ?
    scr_merge(pin_select_q, write_data, byte_enable, SCR_MASK_PIN_SELECT) : pin_select_q;

  // Boot completes once; later pulses are ignored
  assign boot_finish = (boot_state_q == SCR_BOOT_ACTIVE) & boot_done_in;
  assign boot_state_d = boot_finish ? SCR_BOOT_DONE : boot_state_q;

  // Boot flag in its own flop, so the pin has no decode behind it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      boot_active_q <= 1'b1;
    end
    else
    begin
      boot_active_q <= (boot_state_d == SCR_BOOT_ACTIVE);
    end
  end

  // Idle domains: everything but the CPU goes idle at boot end
  always_comb
  begin
    idle_d = idle_q;
    if (write_strobe & hit_idle)
    begin
      idle_d = scr_merge(idle_q, write_data, byte_enable, SCR_MASK_FULL);
    end
    if (boot_finish)
    begin
      idle_d = SCR_MASK_FULL;
      idle_d[SCR_BIT_IDLE_CPU] = 1'b0;
    end
  end

  // Probe clocking only while boot runs; hardware wins over a write
  assign probe_hot = scr_onehot(boot_probe_index_in);
  assign probe_set = (boot_state_q == SCR_BOOT_ACTIVE) & boot_probe_start_in ?
    probe_hot : 32'h0000_0000;
  assign probe_clear = (boot_state_q == SCR_BOOT_ACTIVE) & boot_probe_fail_in ?
    probe_hot : 32'h0000_0000;

  // Clock gates: software write, then probe, then boot end
  assign gates_written[15:0] = (write_strobe & hit_gate1) ?
    scr_merge(gate1_q, write_data, byte_enable, SCR_MASK_FULL) : gate1_q;
  assign gates_written[31:16] = (write_strobe & hit_gate2) ?
    scr_merge(gate2_q, write_data, byte_enable, SCR_MASK_FULL) : gate2_q;
  assign gates_next = boot_finish ? 32'h0000_0000 :
    ((gates_written | probe_set) & ~probe_clear);
  assign gate1_d = gates_next[15:0];
  assign gate2_d = gates_next[31:16];

  // Register update; reset gives 16-bit access and regulators default
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      gate1_q <= SCR_RST_CLOCK_GATE;
      gate2_q <= SCR_RST_CLOCK_GATE;
      usb_sys_q <= SCR_RST_SYSTEM;
      mem_sys_q <= SCR_RST_SYSTEM;
      regulator_q <= SCR_RST_REGULATOR;
      pin_select_q <= SCR_RST_PIN_SELECT;
      idle_q <= SCR_RST_IDLE;
      boot_state_q <= SCR_BOOT_ACTIVE;
    end
    else
    begin
      gate1_q <= gate1_d;
      gate2_q <= gate2_d;
      usb_sys_q <= usb_sys_d;
      mem_sys_q <= mem_sys_d;
      regulator_q <= regulator_d;
      pin_select_q <= pin_select_d;
      idle_q <= idle_d;
      boot_state_q <= boot_state_d;
    end
  end

  // Two-stage synchroniser on the pads before anything reads them
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pad_meta_q <= 6'h00;
      pad_sync_q <= 6'h00;
    end
    else
    begin
      pad_meta_q <= pad_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  // Named selects from the next value, so pins move with the write edge
  assign addr20_pin_select = pin_select_d[5];
  assign addr19_pin_select = pin_select_d[4];
  assign addr18_pin_select = pin_select_d[3];
  assign addr17_pin_select = pin_select_d[2];
  assign addr16_pin_select = pin_select_d[1];
  assign addr15_pin_select = pin_select_d[0];

  // Shared pin routing; a route change does not reset the peripheral,
  // software must do that itself before using it again
  scr_pin_mux u_pin_mux (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .select_next_in({addr20_pin_select, addr19_pin_select, addr18_pin_select,
      addr17_pin_select, addr16_pin_select, addr15_pin_select}),
    .ext_mem_address_line_in(ext_mem_address_line_in),
    .ext_mem_drive_in(ext_mem_drive_in),
    .general_io_line_out_in(general_io_line_out_in),
    .general_io_line_oe_in(general_io_line_oe_in),
    .pad_sync_in(pad_sync_q),
    .pad_out(pad_out),
    .pad_oe_out(pad_oe_out),
    .general_io_line_in_out(general_io_line_in_out)
  );

  // Status word: boot state and synchronised pad levels
  always_comb
  begin
    status_value = 16'h0000;
    status_value[SCR_BIT_STAT_BOOT] = (boot_state_q == SCR_BOOT_ACTIVE);
    status_value[SCR_LSB_STAT_PAD +: 6] = pad_sync_q;
  end

  // Read selection; unmapped words read zero
  always_comb
  begin
    case (1'b1)
      hit_gate1: read_data = gate1_q;
      hit_gate2: read_data = gate2_q;
      hit_usb_sys: read_data = usb_sys_q;
      hit_mem_sys: read_data = mem_sys_q;
      hit_regulator: read_data = regulator_q;
      hit_pin_select: read_data = pin_select_q;
      hit_idle: read_data = idle_q;
      hit_status: read_data = status_value;
      default: read_data = 16'h0000;
    endcase
  end

  // Outputs straight from the registers
  assign periph_clock_enable_out = {gate2_q, gate1_q};
  assign idle_request_out = idle_q;
  assign core_voltage_select_out = regulator_q[SCR_BIT_CORE_VSEL];
  assign usb_regulator_enable_out = regulator_q[SCR_BIT_USB_REG_EN];
  assign mem_byte_access_out = mem_sys_q[1:0];
  assign usb_byte_access_out = usb_sys_q[1:0];
  assign boot_active_out = boot_active_q;
endmodule
`default_nettype wire

/* File: core/scr_wb_slave.sv */
`default_nettype none
module scr_wb_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire scr_pkg::scr_wb_req_t wb_req_in,
  input wire logic [15:0] read_data_in,
  output scr_pkg::scr_wb_rsp_t wb_rsp_out,
  output logic write_strobe_out,
  output logic addr_ok_out,
  output scr_pkg::scr_index_t index_out,
  output logic [15:0] write_data_out,
  output logic [1:0] byte_enable_out
);
  import scr_pkg::*;

  logic ack_q;
  logic ack_d;
  logic [15:0] rdata_q;
  logic request;

  // Word-aligned, inside the 17-bit window, else unmapped
  assign request = wb_req_in.cyc & wb_req_in.stb;
  assign addr_ok_out = (wb_req_in.adr[31:17] == 15'h0000) & (wb_req_in.adr[1:0] == 2'h0);
  assign index_out = wb_req_in.adr[16:2];
  assign write_data_out = wb_req_in.dat[15:0];
  assign byte_enable_out = wb_req_in.sel[1:0];

  // Ack one cycle after the request, dropped the cycle after
  assign ack_d = request & ~ack_q;

  // Write lands on the edge where the master sees ack
  assign write_strobe_out = request & wb_req_in.we & ack_q;

  // Read data captured while the request is stable
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= ack_d ? read_data_in : 16'h0000;
    end
  end

  assign wb_rsp_out.ack = ack_q;
  assign wb_rsp_out.dat = {16'h0000, rdata_q};
endmodule
`default_nettype wire

/* File: sim/scr_top_sva.sv */
`default_nettype none
module scr_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire scr_pkg::scr_wb_req_t wb_req_in,
  input wire scr_pkg::scr_wb_rsp_t wb_rsp_out,
  input wire logic boot_probe_start_in,
  input wire logic boot_probe_fail_in,
  input wire logic [4:0] boot_probe_index_in,
  input wire logic boot_done_in,
  input wire logic [5:0] ext_mem_address_line_in,
  input wire logic ext_mem_drive_in,
  input wire logic [5:0] general_io_line_out_in,
  input wire logic [5:0] general_io_line_oe_in,
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe_out,
  input wire logic [31:0] periph_clock_enable_out,
  input wire logic [15:0] idle_request_out,
  input wire logic core_voltage_select_out,
  input wire logic usb_regulator_enable_out,
  input wire logic [1:0] mem_byte_access_out,
  input wire logic [1:0] usb_byte_access_out,
  input wire logic boot_active_out
);
  import scr_pkg::*;
  logic [5:0] route_q;
  logic sel_wr;

  // Pin select write seen at the ack edge; only the low lane carries the six bits
  assign sel_wr = wb_rsp_out.ack && wb_req_in.cyc && wb_req_in.stb && wb_req_in.we
    && wb_req_in.sel[0] && (wb_req_in.adr == {15'h0000, SCR_IDX_PIN_SELECT, 2'h0});

  // Shadow of the routing bits, so pad checks need no internal probe
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      route_q <= 6'h00;
    else if (sel_wr)
      route_q <= wb_req_in.dat[5:0];
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Bus handshake
  sequence s_req;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  sequence s_probe_on;
    boot_active_out && boot_probe_start_in && !boot_probe_fail_in && !boot_done_in;
  endsequence
  property p_ack_next;
    s_req |=> wb_rsp_out.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_rsp_out.ack |=> !wb_rsp_out.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_dat_quiet;
    (wb_rsp_out.dat[31:16] == 16'h0000) && (wb_rsp_out.ack || wb_rsp_out.dat == 32'h0000_0000);
  endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("read data leaks");

  // Routing takes the new select from the write edge on
  property p_route;
    !$past(rst_in) |-> pad_out == ((route_q & $past(general_io_line_out_in))
      | (~route_q & $past(ext_mem_address_line_in)));
  endproperty
  a_route: assert property (p_route) else $error("pad value");
  property p_route_oe;
    !$past(rst_in) |-> pad_oe_out == ((route_q & $past(general_io_line_oe_in))
      | (~route_q & {6{$past(ext_mem_drive_in)}}));
  endproperty
  a_route_oe: assert property (p_route_oe) else $error("pad enable");

  // Boot sequencing
  property p_probe_on;
    s_probe_on |=> periph_clock_enable_out[$past(boot_probe_index_in)];
  endproperty
  a_probe_on: assert property (p_probe_on) else $error("probe clock off");
  property p_probe_off;
    boot_active_out && boot_probe_fail_in && !boot_done_in
      |=> !periph_clock_enable_out[$past(boot_probe_index_in)];
  endproperty
  a_probe_off: assert property (p_probe_off) else $error("failed probe clock on");
  property p_boot_end;
    boot_active_out && boot_done_in |=> periph_clock_enable_out == 32'h0000_0000
      && idle_request_out == 16'hfffe && !boot_active_out;
  endproperty
  a_boot_end: assert property (p_boot_end) else $error("boot end state");
  property p_boot_once;
    !boot_active_out |=> !boot_active_out;
  endproperty
  a_boot_once: assert property (p_boot_once) else $error("boot restarted");
  property p_reset_vals;
    $fell(rst_in) |-> !usb_regulator_enable_out && !core_voltage_select_out
      && mem_byte_access_out == 2'h0 && usb_byte_access_out == 2'h0 && boot_active_out;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset state");
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import scr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  scr_wb_req_t wb_req_in = '0;
  scr_wb_rsp_t wb_rsp_out;
  logic boot_probe_start_in = 1'b0;
  logic boot_probe_fail_in = 1'b0;
  logic boot_done_in = 1'b0;
  logic [4:0] boot_probe_index_in = 5'h00;
  logic [5:0] ext_mem_address_line_in = 6'h00;
  logic ext_mem_drive_in = 1'b0;
  logic [5:0] general_io_line_out_in = 6'h00;
  logic [5:0] general_io_line_oe_in = 6'h00;
  logic [5:0] pad_in = 6'h00;
  logic [5:0] pad_out, pad_oe_out, general_io_line_in_out;
  logic [31:0] periph_clock_enable_out;
  logic [15:0] idle_request_out;
  logic core_voltage_select_out, usb_regulator_enable_out, boot_active_out;
  logic [1:0] mem_byte_access_out, usb_byte_access_out;
  int n_mismatch = 0;
  int n_checks = 0;
  integer seed = 32'h851c_8543;
  logic act_m = 1'b1;
  logic [15:0] mdl [scr_index_t];
  scr_index_t ids [8] = '{SCR_IDX_CLOCK_GATE_1, SCR_IDX_CLOCK_GATE_2, SCR_IDX_USB_SYSTEM,
    SCR_IDX_MEM_SYSTEM, SCR_IDX_REGULATOR, SCR_IDX_PIN_SELECT, SCR_IDX_IDLE_CONFIG,
    SCR_IDX_BOOT_STATUS};

  scr_top i_dut (.clk_in, .rst_in, .wb_req_in, .wb_rsp_out, .boot_probe_start_in,
    .boot_probe_fail_in, .boot_probe_index_in, .boot_done_in, .ext_mem_address_line_in,
    .ext_mem_drive_in, .general_io_line_out_in, .general_io_line_oe_in, .pad_in, .pad_out,
    .pad_oe_out, .general_io_line_in_out, .periph_clock_enable_out, .idle_request_out,
    .core_voltage_select_out, .usb_regulator_enable_out, .mem_byte_access_out,
    .usb_byte_access_out, .boot_active_out);

  // Free-running 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Writable bits per register; read-only status takes nothing
  function automatic logic [15:0] wmask(input scr_index_t i);
    if (i == SCR_IDX_USB_SYSTEM || i == SCR_IDX_MEM_SYSTEM)
      return SCR_MASK_SYSTEM;
    if (i == SCR_IDX_REGULATOR)
      return SCR_MASK_REGULATOR;
    if (i == SCR_IDX_PIN_SELECT)
      return SCR_MASK_PIN_SELECT;
    return (i == SCR_IDX_BOOT_STATUS) ? 16'h0000 : SCR_MASK_FULL;
  endfunction

  function automatic logic [15:0] rexp(input scr_index_t i);
    if (i == SCR_IDX_BOOT_STATUS)
      return {2'b00, pad_in, 7'h00, act_m};
    return mdl.exists(i) ? mdl[i] : 16'h0000;
  endfunction

  // One classic cycle; the model follows writes, reads are compared
  task automatic wb(input logic [31:0] a, input logic we, input logic [1:0] s,
    input logic [15:0] d);
    logic [15:0] m;
    int n;
    m = {{8{s[1]}}, {8{s[0]}}} & wmask(a[16:2]);
    n = 0;
    @(posedge clk_in);
    wb_req_in <= '{1'b1, 1'b1, we, a, {2'b00, s}, {16'h0000, d}};
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wb_rsp_out.ack !== 1'b1 && n < 20);
    chk(n, 2);
    wb_req_in.cyc <= 1'b0;
    wb_req_in.stb <= 1'b0;
    if (!we)
      chk(wb_rsp_out.dat, (a[31:17] == 0 && a[1:0] == 0) ? rexp(a[16:2]) : 16'h0000);
    else if (a[31:17] == 0 && a[1:0] == 0 && mdl.exists(a[16:2]))
      mdl[a[16:2]] = (mdl[a[16:2]] & ~m) | (d & m);
  endtask

  task automatic outs();
    logic [5:0] s;
    #1;
    s = mdl[SCR_IDX_PIN_SELECT][5:0];
    chk(periph_clock_enable_out, {mdl[SCR_IDX_CLOCK_GATE_2], mdl[SCR_IDX_CLOCK_GATE_1]});
    chk(idle_request_out, mdl[SCR_IDX_IDLE_CONFIG]);
    chk(core_voltage_select_out, mdl[SCR_IDX_REGULATOR][1]);
    chk(usb_regulator_enable_out, mdl[SCR_IDX_REGULATOR][0]);
    chk(mem_byte_access_out, mdl[SCR_IDX_MEM_SYSTEM][1:0]);
    chk(usb_byte_access_out, mdl[SCR_IDX_USB_SYSTEM][1:0]);
    chk(boot_active_out, act_m);
    chk(pad_out, (s & general_io_line_out_in) | (~s & ext_mem_address_line_in));
    chk(pad_oe_out, (s & general_io_line_oe_in) | (~s & {6{ext_mem_drive_in}}));
  endtask

  // One-cycle boot event; probes count only while boot is active
  task automatic boot(input logic st, input logic fl, input logic dn, input logic [4:0] i);
    logic [31:0] g;
    @(posedge clk_in);
    {boot_probe_start_in, boot_probe_fail_in, boot_done_in} <= {st, fl, dn};
    boot_probe_index_in <= i;
    @(posedge clk_in);
    {boot_probe_start_in, boot_probe_fail_in, boot_done_in} <= 3'h0;
    g = {mdl[SCR_IDX_CLOCK_GATE_2], mdl[SCR_IDX_CLOCK_GATE_1]};
    if (act_m && dn)
    begin
      g = 32'h0000_0000;
      mdl[SCR_IDX_IDLE_CONFIG] = 16'hfffe;
      act_m = 1'b0;
    end
    else if (act_m && (fl || st))
      g[i] = !fl;
    {mdl[SCR_IDX_CLOCK_GATE_2], mdl[SCR_IDX_CLOCK_GATE_1]} = g;
    outs();
  endtask

  // Main sequence: reset state, boot, random traffic, codes, refusals, pad input
  initial
  begin
    foreach (ids[k])
      mdl[ids[k]] = 16'h0000;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    outs();
    foreach (ids[k])
      wb({15'h0000, ids[k], 2'h0}, 1'b0, 2'h3, 16'h0000);
    boot(1'b1, 1'b0, 1'b0, 5'd3);
    boot(1'b1, 1'b0, 1'b0, 5'd20);
    boot(1'b0, 1'b1, 1'b0, 5'd3);
    boot(1'b1, 1'b1, 1'b0, 5'd20);
    boot(1'b1, 1'b0, 1'b1, 5'd31);
    boot(1'b1, 1'b0, 1'b0, 5'd7);
    for (int k = 0; k < 48; k++)
    begin
      @(posedge clk_in);
      ext_mem_address_line_in <= 6'($random(seed));
      general_io_line_out_in <= 6'($random(seed));
      general_io_line_oe_in <= 6'($random(seed));
      ext_mem_drive_in <= 1'($random(seed));
      // Random write to each register in turn, pin select included, while the pad sources keep changing
      wb({15'h0000, ids[k % 8], 2'h0}, 1'b1, 2'($random(seed)), 16'($random(seed)));
      outs();
      wb({15'h0000, ids[k % 8], 2'h0}, 1'b0, 2'h3, 16'h0000);
    end
    for (int c = 0; c < 4; c++)
    begin
      wb({15'h0000, SCR_IDX_MEM_SYSTEM, 2'h0}, 1'b1, 2'h1, 16'(c));
      wb({15'h0000, SCR_IDX_USB_SYSTEM, 2'h0}, 1'b1, 2'h1, 16'(c));
      outs();
    end
    wb({15'h0000, 15'h1c44, 2'h0}, 1'b1, 2'h3, 16'hffff);
    wb({15'h0000, 15'h1c44, 2'h0}, 1'b0, 2'h3, 16'h0000);
    wb({15'h0000, SCR_IDX_CLOCK_GATE_1, 2'h2}, 1'b1, 2'h3, 16'h5a5a);
    wb({15'h0000, SCR_IDX_CLOCK_GATE_1, 2'h1}, 1'b0, 2'h3, 16'h0000);
    wb({15'h0001, SCR_IDX_CLOCK_GATE_1, 2'h0}, 1'b0, 2'h3, 16'h0000);
    wb({15'h0000, SCR_IDX_CLOCK_GATE_1, 2'h0}, 1'b0, 2'h3, 16'h0000);
    @(posedge clk_in);
    pad_in <= 6'($random(seed));
    repeat (4) @(posedge clk_in);
    #1;
    chk(general_io_line_in_out, mdl[SCR_IDX_PIN_SELECT][5:0] & pad_in);
    wb({15'h0000, SCR_IDX_BOOT_STATUS, 2'h0}, 1'b0, 2'h3, 16'h0000);
    final_report();
  end

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the run needs
  initial
  begin
    #(25 * 20000);
    n_mismatch++;
    final_report();
  end
endmodule

bind scr_top scr_sva i_sva (.clk_in, .rst_in, .wb_req_in, .wb_rsp_out, .boot_probe_start_in,
  .boot_probe_fail_in, .boot_probe_index_in, .boot_done_in, .ext_mem_address_line_in,
  .ext_mem_drive_in, .general_io_line_out_in, .general_io_line_oe_in, .pad_out, .pad_oe_out,
  .periph_clock_enable_out, .idle_request_out, .core_voltage_select_out,
  .usb_regulator_enable_out, .mem_byte_access_out, .usb_byte_access_out, .boot_active_out);
`default_nettype wire
